// ===== core/sqfc_cfg.svh
`ifndef SQFC_CFG_SVH
`define SQFC_CFG_SVH

// Register indices; the byte address on the bus is four times the index.
`define SQFC_IDX_TXQC 16'h705a
`define SQFC_IDX_RXQC 16'h705b
`define SQFC_IDX_TXDATA 16'h7070
`define SQFC_IDX_RXDATA 16'h7071
`define SQFC_IDX_ISTAT 16'h7072
`define SQFC_IDX_IMASK 16'h7073

// Transmit queue control fields.
`define SQFC_B_CHRST 15
`define SQFC_B_FENA 14
`define SQFC_B_QRST 13
`define SQFC_B_CNT_LSB 8
`define SQFC_B_IFLAG 7
`define SQFC_B_ICLR 6
`define SQFC_B_IENA 5

// Receive queue control fields beyond the shared layout.
`define SQFC_B_OVF 15
`define SQFC_B_OVCLR 14

// Interrupt status and mask bits.
`define SQFC_I_TX 0
`define SQFC_I_RX 1

// Reset values.
`define SQFC_RST_TXQC 16'ha000
`define SQFC_RST_RXQC 16'h201f

// Queue depth in words.
`define SQFC_DEPTH 3'h4

`endif

// ===== core/sqfc_pkg.sv
`default_nettype none
package sqfc_pkg;
  typedef logic [7:0] sqfc_word_t;
  typedef logic [2:0] sqfc_count_t;
  typedef logic [4:0] sqfc_level_t;
  typedef logic [1:0] sqfc_ptr_t;
endpackage : sqfc_pkg
`default_nettype wire

// ===== core/sqfc_queue_if.sv
`timescale 1ns/1ns
`default_nettype none
interface sqfc_queue_if;
  import sqfc_pkg::*;
  logic flush;
  logic push;
  logic pop;
  sqfc_word_t push_data;
  sqfc_word_t head;
  sqfc_count_t count;
  logic full;
  logic empty;
  logic overflow;
  modport owner (output flush, push, pop, push_data, input head, count, full, empty, overflow);
  modport store (input flush, push, pop, push_data, output head, count, full, empty, overflow);
endinterface : sqfc_queue_if
`default_nettype wire

// ===== core/sqfc_queue.sv
`timescale 1ns/1ns
`default_nettype none
`include "sqfc_cfg.svh"
module sqfc_queue (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Queue port
  sqfc_queue_if.store q
);
  import sqfc_pkg::*;

  sqfc_word_t mem [0:3];
  sqfc_ptr_t rd;
  sqfc_ptr_t wr;
  sqfc_count_t cnt;
  logic ovf;

  wire do_pop = q.pop && !q.empty;
  // A push into a full queue overwrites the oldest word, so the first one received is lost.
  wire drop = q.push && q.full && !do_pop;
  wire grow = q.push && !q.full && !do_pop;
  wire shrink = do_pop && !q.push;

  always_ff @(posedge clk_i) begin
    if (q.push) begin
      mem[wr] <= q.push_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || q.flush) begin
      rd <= 2'h0; // RL1
      wr <= 2'h0;
      cnt <= 3'h0;
      ovf <= 1'b0;
    end else begin
      if (q.push) begin
        wr <= wr + 2'h1;
      end
      if (do_pop || drop) begin
        rd <= rd + 2'h1;
      end
      if (grow) begin
        cnt <= cnt + 3'h1;
      end else if (shrink) begin
        cnt <= cnt - 3'h1;
      end
      ovf <= drop; // RL10
    end
  end

  assign q.head = mem[rd];
  assign q.count = cnt;
  assign q.full = (cnt == `SQFC_DEPTH);
  assign q.empty = (cnt == 3'h0);
  assign q.overflow = ovf;
endmodule : sqfc_queue
`default_nettype wire

// ===== core/sqfc_top.sv
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "sqfc_cfg.svh"
// How it works
// RL1: Transmit queue reset bit at zero holds the queue pointers at zero.
// RL2: Transmit word count reads as a five-bit binary value from zero to four.
// RL3: Read-only transmit interrupt flag shows that the level condition has occurred.
// RL4: Writing one to the clear bit clears the flag; the bit reads zero.
// RL5: Transmit level interrupt is forwarded only while its enable bit is one.
// RL6: Transmit condition holds whenever the word count is at or below the level.
// RL7: Software keeps the transmit level at four or below.
// RL8: Software leaves the transmit level at zero by default.
// RL9: Receive control register holds overflow, clear, reset, count, flag, clear, enable, level.
// RL10: Receive overflow flag sets when a word arrives into a full queue.
// RL11: Channel reset bit at zero resets both channels, keeping queue configuration.
// RL12: Level interrupts and queued status work only while the feature enable is one.
// RL13: Transmit flag stays set until software clears it.
module sqfc_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [17:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Transmit side toward the shift logic
  output sqfc_pkg::sqfc_word_t tx_data_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  // Receive side from the shift logic
  input wire sqfc_pkg::sqfc_word_t rx_data_i,
  input wire logic rx_valid_i,
  // Channel state and interrupt
  output logic channel_run_o,
  output logic irq_o
);
  import sqfc_pkg::*;

  // Reset images held as sized constants, so that single fields can be picked out of them.
  localparam logic [15:0] TXQC_RST = `SQFC_RST_TXQC;
  localparam logic [15:0] RXQC_RST = `SQFC_RST_RXQC;

  // True when the first operand is at or below the second.
  function automatic logic level_le(input logic [4:0] a, input logic [4:0] b);
    level_le = (a <= b);
  endfunction : level_le

  // Byte-lane merge of a write into a 16-bit register image.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] d, input logic [15:0] m);
    merge16 = (old & ~m) | (d & m);
  endfunction : merge16

  sqfc_queue_if txq ();
  sqfc_queue_if rxq ();

  sqfc_queue u_txq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .q(txq)
  );

  sqfc_queue u_rxq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .q(rxq)
  );

  // Shared and transmit control bits.
  logic serial_channel_reset;
  logic queue_feature_enable;
  logic tx_queue_reset;
  logic tx_queue_int_flag;
  logic tx_queue_int_enable;
  sqfc_level_t tx_queue_int_level;

  // Receive control bits.
  logic rx_queue_overflow;
  logic rx_queue_reset;
  logic rx_queue_int_flag;
  logic rx_queue_int_enable;
  sqfc_level_t rx_queue_int_level;

  // Interrupt block.
  logic [1:0] int_status;
  logic [1:0] int_mask;
  logic [1:0] fwd_q;

  // Bus decode.
  wire req = cyc_i && stb_i;
  wire wr_acc = req && ack_o && we_i;
  wire rd_acc = req && ack_o && !we_i;
  wire [15:0] idx = adr_i[17:2];
  wire hit_txqc = (idx == `SQFC_IDX_TXQC);
  wire hit_rxqc = (idx == `SQFC_IDX_RXQC);
  wire hit_txd = (idx == `SQFC_IDX_TXDATA);
  wire hit_rxd = (idx == `SQFC_IDX_RXDATA);
  wire hit_ist = (idx == `SQFC_IDX_ISTAT);
  wire hit_imk = (idx == `SQFC_IDX_IMASK);
  wire [15:0] wmask = {{8{sel_i[1]}}, {8{sel_i[0]}}};
  wire [15:0] wdata = dat_i[15:0];
  wire [15:0] wbits = wdata & wmask;

  // Counts as software sees them; zero while the queue feature is off.
  wire [4:0] tx_queue_count = queue_feature_enable ? {2'h0, txq.count} : 5'h00; // RL2 RL12
  wire [4:0] rx_queue_count = queue_feature_enable ? {2'h0, rxq.count} : 5'h00; // RL12

  // Register images.
  wire [15:0] txqc_img = {serial_channel_reset, queue_feature_enable, tx_queue_reset, tx_queue_count,
                          tx_queue_int_flag, 1'b0, tx_queue_int_enable, tx_queue_int_level}; // RL4
  wire [15:0] rxqc_img = {rx_queue_overflow, 1'b0, rx_queue_reset, rx_queue_count,
                          rx_queue_int_flag, 1'b0, rx_queue_int_enable, rx_queue_int_level}; // RL9
  wire [15:0] txqc_new = merge16(txqc_img, wdata, wmask);
  wire [15:0] rxqc_new = merge16(rxqc_img, wdata, wmask);
  wire [15:0] rxd_img = {8'h00, rxq.empty ? 8'h00 : rxq.head};

  wire [15:0] rdata = hit_txqc ? txqc_img :
                      hit_rxqc ? rxqc_img :
                      hit_rxd ? rxd_img :
                      hit_ist ? {14'h0000, int_status} :
                      hit_imk ? {14'h0000, int_mask} :
                      16'h0000;

  // Write-one strobes.
  wire wr_txqc = wr_acc && hit_txqc;
  wire wr_rxqc = wr_acc && hit_rxqc;
  wire tx_int_clear = wr_txqc && wbits[`SQFC_B_ICLR]; // RL4
  wire rx_int_clear = wr_rxqc && wbits[`SQFC_B_ICLR];
  wire rx_overflow_clear = wr_rxqc && wbits[`SQFC_B_OVCLR];

  // Level conditions, live only while the queue feature is on.
  wire tx_cond = queue_feature_enable && level_le(tx_queue_count, tx_queue_int_level); // RL6 RL12
  // The receive side fires once the count reaches its level; the reset level of 31 never matches.
  wire rx_cond = queue_feature_enable && level_le(rx_queue_int_level, rx_queue_count); // RL12

  // Forwarded interrupt levels and their rising edges.
  wire [1:0] fwd = {rx_queue_int_flag && rx_queue_int_enable,
                    tx_queue_int_flag && tx_queue_int_enable}; // RL5
  wire [1:0] int_event = fwd & ~fwd_q;
  wire [1:0] ist_clear = (wr_acc && hit_ist) ? wbits[1:0] : 2'h0;

  // Queue hookup. A channel reset empties both queues but leaves every control bit alone.
  assign txq.flush = !tx_queue_reset || !serial_channel_reset; // RL1 RL11
  assign rxq.flush = !rx_queue_reset || !serial_channel_reset; // RL11
  // A write to a full transmit queue is dropped; software should check the count first.
  assign txq.push = wr_acc && hit_txd && sel_i[0] && !txq.full && serial_channel_reset;
  assign txq.push_data = dat_i[7:0];
  assign txq.pop = tx_valid_o && tx_ready_i;
  assign rxq.push = rx_valid_i && serial_channel_reset;
  assign rxq.push_data = rx_data_i;
  assign rxq.pop = rd_acc && hit_rxd;

  assign tx_valid_o = serial_channel_reset && !txq.empty;
  assign tx_data_o = txq.head;
  assign channel_run_o = serial_channel_reset;
  assign irq_o = |(int_status & int_mask);

  // Bus answer: one wait state, ack for a single cycle, effects at the ack edge.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= req && !ack_o;
      if (req && !ack_o) begin
        dat_o <= {16'h0000, rdata};
      end
    end
  end

  // Transmit control and flag.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_channel_reset <= TXQC_RST[`SQFC_B_CHRST];
      queue_feature_enable <= TXQC_RST[`SQFC_B_FENA];
      tx_queue_reset <= TXQC_RST[`SQFC_B_QRST];
      tx_queue_int_enable <= TXQC_RST[`SQFC_B_IENA];
      tx_queue_int_level <= TXQC_RST[4:0];
      tx_queue_int_flag <= 1'b0;
    end else begin
      if (wr_txqc) begin
        serial_channel_reset <= txqc_new[`SQFC_B_CHRST]; // RL11
        queue_feature_enable <= txqc_new[`SQFC_B_FENA];
        tx_queue_reset <= txqc_new[`SQFC_B_QRST];
        tx_queue_int_enable <= txqc_new[`SQFC_B_IENA];
        tx_queue_int_level <= txqc_new[4:0];
      end
      // A set in the same cycle as a clear wins, so no event is lost.
      if (tx_cond) begin
        tx_queue_int_flag <= 1'b1; // RL3 RL13
      end else if (tx_int_clear) begin
        tx_queue_int_flag <= 1'b0; // RL4
      end
    end
  end

  // Receive control, flag and overflow.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_queue_reset <= RXQC_RST[`SQFC_B_QRST];
      rx_queue_int_enable <= RXQC_RST[`SQFC_B_IENA];
      rx_queue_int_level <= RXQC_RST[4:0];
      rx_queue_int_flag <= 1'b0;
      rx_queue_overflow <= 1'b0;
    end else begin
      if (wr_rxqc) begin
        rx_queue_reset <= rxqc_new[`SQFC_B_QRST]; // RL9
        rx_queue_int_enable <= rxqc_new[`SQFC_B_IENA];
        rx_queue_int_level <= rxqc_new[4:0];
      end
      if (rx_cond) begin
        rx_queue_int_flag <= 1'b1;
      end else if (rx_int_clear) begin
        rx_queue_int_flag <= 1'b0;
      end
      if (rxq.overflow) begin
        rx_queue_overflow <= 1'b1; // RL10
      end else if (rx_overflow_clear) begin
        rx_queue_overflow <= 1'b0;
      end
    end
  end

  // Interrupt status is sticky and cleared by writing ones; a new event beats the clear.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_status <= 2'h0;
      int_mask <= 2'h0;
      fwd_q <= 2'h0;
    end else begin
      fwd_q <= fwd;
      int_status <= (int_status & ~ist_clear) | int_event; // RL5
      if (wr_acc && hit_imk && sel_i[0]) begin
        int_mask <= dat_i[1:0];
      end
    end
  end
endmodule : sqfc_top
`default_nettype wire

// ===== tb/sqfc_checker.sv
`timescale 1ns/1ns
`default_nettype none
`include "sqfc_cfg.svh"
module sqfc_checker (
  // Watched ports
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [17:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic tx_valid_o,
  input wire logic channel_run_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire tx_rd = ack_o && !we_i && adr_i[17:2] == `SQFC_IDX_TXQC;
  wire rx_rd = ack_o && !we_i && adr_i[17:2] == `SQFC_IDX_RXQC;
  wire tx_wr = ack_o && we_i && sel_i[1] && adr_i[17:2] == `SQFC_IDX_TXQC;
  wire mask_off = ack_o && we_i && sel_i[0] && adr_i[17:2] == `SQFC_IDX_IMASK && dat_i[1:0] == 2'h0;
  a_ack_one_cycle: assert property (ack_o |=> !ack_o) else $error("ack held");
  a_ack_after_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
  a_ack_needs_req: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack unasked");
  a_upper_half_zero: assert property (dat_o[31:16] == 16'h0) else $error("upper data");
  a_tx_count_max: assert property (tx_rd |-> dat_o[12:8] <= 5'h4) else $error("count range");
  a_tx_clear_zero: assert property (tx_rd |-> !dat_o[6]) else $error("tx clear bit");
  a_rx_clear_zero: assert property (rx_rd |-> !dat_o[14] && !dat_o[6]) else $error("rx clear bits");
  a_chan_reset_hold: assert property (tx_wr && !dat_i[15] |=> !channel_run_o) else $error("run");
  a_run_gates_valid: assert property (!channel_run_o |-> !tx_valid_o) else $error("valid in reset");
  // The flush acts at the edge after the control bit lands, so the queue is empty one cycle later.
  a_txq_flush: assert property (tx_wr && !dat_i[13] |=> ##1 !tx_valid_o) else $error("tx flush");
  a_mask_off_irq: assert property (mask_off |=> !irq_o) else $error("irq masked");
  c_flush: cover property (tx_wr && !dat_i[13]);
  c_irq: cover property (irq_o);
  c_tx_valid: cover property (tx_valid_o);
endmodule : sqfc_checker
bind sqfc_top sqfc_checker i_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .tx_valid_o(tx_valid_o),
  .channel_run_o(channel_run_o), .irq_o(irq_o));
`default_nettype wire

// ===== tb/sqfc_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "sqfc_cfg.svh"
module sqfc_tb_top;
  import sqfc_pkg::*;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, tx_ready_i, rx_valid_i, ack_o, tx_valid_o, channel_run_o, irq_o;
  logic [17:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o;
  sqfc_word_t tx_data_o, rx_data_i;
  logic [15:0] rdata;
  int fail_count = 0;
  int total_checks = 0;
  sqfc_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
    .tx_ready_i(tx_ready_i), .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i), .channel_run_o(channel_run_o),
    .irq_o(irq_o));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic stop_test;
    if (fail_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // One classic cycle; the answer is taken at the edge where ack is seen high.
  task automatic bus(input logic w, input logic [15:0] idx, input logic [15:0] d);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'h0};
    dat_i <= {16'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1) begin
      fail_count++;
      stop_test();
    end
    rdata = dat_o[15:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : bus
  task automatic wr(input logic [15:0] idx, input logic [15:0] d);
    bus(1'b1, idx, d);
  endtask : wr
  task automatic rd(input logic [15:0] idx, input logic [15:0] exp, input string name);
    bus(1'b0, idx, 16'h0);
    chk(name, exp, rdata);
  endtask : rd
  initial begin
    {rst_i, cyc_i, stb_i, we_i, tx_ready_i, rx_valid_i} = 6'h20;
    adr_i = 18'h0;
    sel_i = 4'h3;
    dat_i = 32'h0;
    rx_data_i = 8'h0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`SQFC_IDX_TXQC, 16'ha000, "txqc");
    rd(`SQFC_IDX_RXQC, 16'h201f, "rxqc");
    rd(16'h0100, 16'h0, "unmapped");
    wr(`SQFC_IDX_TXQC, 16'he000);
    rd(`SQFC_IDX_TXQC, 16'he080, "flag_empty");
    for (int i = 0; i < 5; i++) wr(`SQFC_IDX_TXDATA, 16'h0011 + 16'(i));
    rd(`SQFC_IDX_TXQC, 16'he480, "full_sticky");
    wr(`SQFC_IDX_TXQC, 16'he040);
    rd(`SQFC_IDX_TXQC, 16'he400, "flag_clear");
    wr(`SQFC_IDX_TXQC, 16'he023);
    chk("tx_head", 16'h0011, {8'h0, tx_data_o});
    tx_ready_i <= 1'b1;
    @(posedge clk_i);
    tx_ready_i <= 1'b0;
    rd(`SQFC_IDX_TXQC, 16'he3a3, "level_match");
    chk("irq_masked", 16'h0, {15'h0, irq_o});
    wr(`SQFC_IDX_IMASK, 16'h0001);
    rd(`SQFC_IDX_ISTAT, 16'h0001, "status");
    chk("irq_on", 16'h1, {15'h0, irq_o});
    wr(`SQFC_IDX_IMASK, 16'h0000);
    // The mask lands at the ack edge, so the output is looked at one edge later.
    @(posedge clk_i);
    chk("irq_mask_off", 16'h0, {15'h0, irq_o});
    wr(`SQFC_IDX_IMASK, 16'h0001);
    wr(`SQFC_IDX_TXQC, 16'he003);
    wr(`SQFC_IDX_ISTAT, 16'h0001);
    rd(`SQFC_IDX_ISTAT, 16'h0, "status_clr");
    chk("irq_off", 16'h0, {15'h0, irq_o});
    wr(`SQFC_IDX_TXQC, 16'hc003);
    rd(`SQFC_IDX_TXQC, 16'hc083, "q_reset");
    chk("tx_valid", 16'h0, {15'h0, tx_valid_o});
    wr(`SQFC_IDX_TXQC, 16'he003);
    // Five back-to-back words into a four-word queue.
    @(posedge clk_i);
    rx_valid_i <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rx_data_i <= 8'ha0 + 8'(i);
      @(posedge clk_i);
    end
    rx_valid_i <= 1'b0;
    rd(`SQFC_IDX_RXQC, 16'ha41f, "rx_ovf");
    rd(`SQFC_IDX_RXDATA, 16'h00a1, "rx_head");
    wr(`SQFC_IDX_RXQC, 16'h601f);
    rd(`SQFC_IDX_RXQC, 16'h231f, "ovf_clear");
    // Three words held against a receive level of three sets the receive flag and its status bit.
    wr(`SQFC_IDX_RXQC, 16'h2023);
    rd(`SQFC_IDX_RXQC, 16'h23a3, "rx_level");
    rd(`SQFC_IDX_ISTAT, 16'h0002, "rx_status");
    wr(`SQFC_IDX_TXQC, 16'h6003);
    rd(`SQFC_IDX_TXQC, 16'h6083, "chan_reset");
    chk("run", 16'h0, {15'h0, channel_run_o});
    wr(`SQFC_IDX_TXQC, 16'ha003);
    wr(`SQFC_IDX_TXDATA, 16'h0055);
    rd(`SQFC_IDX_TXQC, 16'ha083, "feature_off");
    stop_test();
  end
endmodule : sqfc_tb_top
`default_nettype wire
